// ===== hdl/cmdv_top.sv
// Top of the multiply/divide unit: AHB-Lite slave, operand bytes,
// sequence counter and datapath. Models a cascade of one to four
// byte slices; slice 0 is least significant.
// Assumes single word transfers and a synchronous clear input.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module cmdv_top (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clear_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             overflow_n_o
);
    logic [1:0]             rst_sync_q;  // Reset release chain
    logic [31:0]            x_q;         // Divisor / multiplicand
    logic [31:0]            y_q;         // Upper half / remainder
    logic [31:0]            z_q;         // Lower half / quotient
    logic [7:0]             ctl_q;       // Control word
    logic [1:0]             seq_q;       // Sequence counter
    logic                   ovf_n_q;     // Overflow, low active
    cmdv_pkg::cmdv_aphase_t aph_q;       // Pending data phase
    logic [31:0]            hrdata_q;    // Read data
    logic                   hready_q;    // Ready out
    logic                   hresp_q;     // Response
    logic                   gen_busy;    // Operation running
    logic                   gen_pulse;   // Shift pulse
    logic                   gen_first;   // Setup pulse
    logic                   gen_done;    // Last pulse
    logic [31:0]            y_step;      // Datapath next Y
    logic [31:0]            z_step;      // Datapath next Z

    wire rst_n = rst_sync_q[1];
    wire clear = !clear_n_i;

    wire [1:0]  num    = ctl_q[cmdv_pkg::CTL_NUM_LSB +: 2];
    wire [1:0]  op     = ctl_q[cmdv_pkg::CTL_OP_LSB +: 2];
    wire [5:0]  wbits  = 6'((int'(num) + 1) * cmdv_pkg::BYTE_W);
    wire [31:0] mask   = 32'(64'hFFFF_FFFF >> (6'h20 - wbits));
    wire [31:0] msb    = 32'(33'h0_0000_0001 << (wbits - 6'h01));
    wire [31:0] xm     = x_q & mask;
    wire [31:0] ym     = y_q & mask;
    wire [31:0] zm     = z_q & mask;

    // Word selects of the four register slots
    localparam logic [1:0] ADDR_CTL_SEL = cmdv_pkg::ADDR_CTL[3:2];
    localparam logic [1:0] ADDR_X_SEL   = cmdv_pkg::ADDR_X[3:2];
    localparam logic [1:0] ADDR_Y_SEL   = cmdv_pkg::ADDR_Y[3:2];
    localparam logic [1:0] ADDR_Z_SEL   = cmdv_pkg::ADDR_Z[3:2];

    wire        take   = hsel_i && htrans_i[1] && hready_i;
    wire        mapped = (haddr_i[31:4] == 28'h000_0000);
    wire [1:0]  rsel_a = haddr_i[3:2];
    wire [1:0]  rsel_d = aph_q.addr[3:2];
    wire        opnd_a = mapped && (rsel_a != ADDR_CTL_SEL);
    wire        opnd_d = aph_q.mapped && (rsel_d != ADDR_CTL_SEL);

    wire        rd_take  = take && !hwrite_i && !gen_busy;
    wire        wr_data  = aph_q.valid && aph_q.wr && aph_q.mapped && !gen_busy;
    wire        opnd_rd  = rd_take && opnd_a;
    wire        opnd_wr  = wr_data && opnd_d;
    wire        ctl_wr   = wr_data && !opnd_d;
    wire        seq_step = opnd_rd || opnd_wr;
    wire        hit      = (seq_q <= num);
    wire [4:0]  lane     = {seq_q, 3'h0};
    wire [31:0] lane_msk = 32'(32'h0000_00FF << lane);
    wire [31:0] wr_byte  = 32'({24'h00_0000, hwdata_i[7:0]} << lane);
    wire        wr_x     = opnd_wr && hit && (rsel_d == ADDR_X_SEL);
    wire        wr_y     = opnd_wr && hit && (rsel_d == ADDR_Y_SEL);
    wire        wr_z     = opnd_wr && hit && (rsel_d == ADDR_Z_SEL);
    wire [31:0] rd_word  = (rsel_a == ADDR_X_SEL) ? x_q :
                           (rsel_a == ADDR_Y_SEL) ? y_q : z_q;
    wire [7:0]  rd_byte  = 8'(rd_word >> lane);
    wire [7:0]  status   = {gen_busy, 6'h00, !ovf_n_q};
    wire [31:0] rd_data  = !(take && !hwrite_i && mapped) ? 32'h0000_0000 :
                           !opnd_a ? {24'h00_0000, status} :
                           (opnd_rd && hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    // New control word and its effects
    wire [7:0]  ctl_new  = hwdata_i[7:0];
    wire [1:0]  op_new   = ctl_new[cmdv_pkg::CTL_OP_LSB +: 2];
    wire        start    = ctl_wr && ((op_new == cmdv_pkg::OP_MUL) ||
                                      (op_new == cmdv_pkg::OP_DIV));
    wire        y_clr    = ctl_wr && ctl_new[cmdv_pkg::CTL_YRST];
    wire        z_clr    = ctl_wr && ctl_new[cmdv_pkg::CTL_ZRST];
    wire [1:0]  num_new  = ctl_new[cmdv_pkg::CTL_NUM_LSB +: 2];
    wire [31:0] mask_new = 32'(64'hFFFF_FFFF >> (6'h20 - 6'((int'(num_new) + 1) * 8)));
    wire [31:0] y_eff    = y_clr ? 32'h0000_0000 : (y_q & mask_new);
    wire        ovf_new  = y_eff >= (x_q & mask_new);
    wire        dp_step  = gen_pulse && !gen_first;

    // clear or bit 6 resets counter
    wire [1:0]  seq_d = clear ? num :
                        (ctl_wr && ctl_new[cmdv_pkg::CTL_SEQRST]) ? num_new :
                        seq_step ? seq_q - 2'h1 : seq_q;

    // Reset release through two flops
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Datapath step
    cmdv_step u_step (
        .op_i   (op),
        .x_i    (xm),
        .y_i    (ym),
        .z_i    (zm),
        .msb_i  (msb),
        .mask_i (mask),
        .y_o    (y_step),
        .z_o    (z_step)
    );

    // Shift pulse generator
    cmdv_shift_gen u_gen (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n),
        .clear_i (clear),
        .start_i (start),
        .presc_i (ctl_q[cmdv_pkg::CTL_PRESC]),
        .num_i   (num),
        .busy_o  (gen_busy),
        .pulse_o (gen_pulse),
        .first_o (gen_first),
        .done_o  (gen_done)
    );

    // Bus slave response
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            aph_q    <= '0;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
        end else begin
            aph_q    <= {take, hwrite_i, mapped, haddr_i[3:0]};
            hrdata_q <= rd_data;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
        end
    end

    // Control word and overflow latch
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q   <= cmdv_pkg::CTL_RESET;
            ovf_n_q <= 1'b1;
        end else if (ctl_wr) begin
            ctl_q   <= ctl_new;
            ovf_n_q <= !ovf_new;
        end else if (clear) begin
            ctl_q[1:0] <= cmdv_pkg::OP_NONE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= 2'h0;
        end else begin
            seq_q <= seq_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            x_q <= cmdv_pkg::OPND_RESET;
            y_q <= cmdv_pkg::OPND_RESET;
            z_q <= cmdv_pkg::OPND_RESET;
        end else begin
            if (wr_x) begin
                x_q <= (x_q & ~lane_msk) | wr_byte;
            end
            if (dp_step) begin
                y_q <= y_step;
            end else if (y_clr) begin
                y_q <= cmdv_pkg::OPND_RESET;
            end else if (wr_y) begin
                y_q <= (y_q & ~lane_msk) | wr_byte;
            end
            if (dp_step) begin
                z_q <= z_step;
            end else if (z_clr) begin
                z_q <= cmdv_pkg::OPND_RESET;
            end else if (wr_z) begin
                z_q <= (z_q & ~lane_msk) | wr_byte;
            end
        end
    end

    assign hrdata_o     = hrdata_q;
    assign hreadyout_o  = hready_q;
    assign hresp_o      = hresp_q;
    assign overflow_n_o = ovf_n_q;

    // Helper: pulses seen and operand snapshot
    logic [5:0]  chk_cnt_q;
    logic [31:0] chk_x_q;
    logic [31:0] chk_y_q;
    logic [31:0] chk_z_q;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            chk_cnt_q <= 6'h00;
            chk_x_q   <= 32'h0000_0000;
            chk_y_q   <= 32'h0000_0000;
            chk_z_q   <= 32'h0000_0000;
        end else begin
            if (start) begin
                chk_cnt_q <= 6'h00;
            end else if (gen_pulse) begin
                chk_cnt_q <= chk_cnt_q + 6'h01;
            end
            if (gen_first) begin
                chk_x_q <= xm;
                chk_y_q <= ym;
                chk_z_q <= zm;
            end
        end
    end
    wire [63:0] res_act = ({32'h0, y_q} << wbits) | {32'h0, z_q};
    wire [63:0] mul_exp = (64'(chk_x_q) * 64'(chk_z_q)) + 64'(chk_y_q);
    wire [63:0] div_lhs = (64'(z_q) * 64'(chk_x_q)) + 64'(y_q);
    wire [63:0] div_rhs = ({32'h0, chk_y_q} << wbits) | {32'h0, chk_z_q};
    wire [5:0]  pls_tot = 6'(int'(wbits) + cmdv_pkg::SETUP_PULSES);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    op_length_a: assert property (gen_done |-> (chk_cnt_q + 6'h01 == pls_tot))
        else $error("operation pulse count wrong");
    mul_result_a: assert property ((gen_done && op == cmdv_pkg::OP_MUL) |=>
        (res_act == mul_exp)) else $error("multiply result wrong");
    div_result_a: assert property ((gen_done && op == cmdv_pkg::OP_DIV &&
        chk_y_q < chk_x_q) |=> (div_lhs == div_rhs) && (y_q < chk_x_q))
        else $error("divide result wrong");
    start_ctl_a: assert property ($rose(gen_busy) |-> $past(ctl_wr))
        else $error("operation started without control write");
    seq_reset_a: assert property ((ctl_wr && ctl_new[6] && clear_n_i) |=>
        (seq_q == $past(num_new))) else $error("sequence reset wrong");
    seq_step_a: assert property ((seq_step && !ctl_wr && clear_n_i) |=>
        (seq_q == $past(seq_q) - 2'h1)) else $error("sequence step wrong");
    busy_hold_a: assert property (gen_busy |=> $stable(x_q) &&
        ($stable(ctl_q) || !$past(clear_n_i))) else $error("register changed while busy");
    clear_seq_a: assert property (!clear_n_i |=> !gen_busy &&
        (seq_q == num)) else $error("clear did not reset sequencer");
    presc_gap_a: assert property ((gen_pulse && !gen_done && ctl_q[7] && num == 2'h0)
        |=> !gen_pulse ##1 gen_pulse) else $error("prescaler spacing wrong");
    byte_read_a: assert property ((hrdata_q[31:8] == 24'h00_0000) &&
        ((hrdata_q == 32'h0000_0000) || (aph_q.valid && !aph_q.wr)))
        else $error("read data wider than a byte");
endmodule

// ===== hdl/cmdv_pkg.sv
// Constants, types and carriers of the cascadable multiply/divide unit.
// Assumes a single 20 MHz clock and an AHB-Lite master in front of it.
// Notes on behaviour
// - Operands are unsigned binary numbers
// - Multiply adds, shifts right; divide subtracts, shifts left
// - Multiply yields a 16N-bit product
// - Divide 16N by 8N gives quotient, remainder
// - Cascade count N is one to four
// - Each operation takes 8N plus one pulses
// - Three operand registers hold operands, then results
// - Only a control write starts an operation
// - Status register holds an overflow flag
// - Two select lines pick the accessed register
// - Clear resets counters and pulse generator
// - Control bit 6 also clears sequence counters
// - Repeated accesses step most to least significant
// - Counter reset selects the most significant unit
// - Four-unit counter wraps back to first unit
// - Counter steps per access; matching unit responds
// - Prescaler divides shift clock by 2/4/8
// - Divide leaves remainder, quotient; divisor unchanged
// - Multiply adds prior upper half; multiplicand kept
package cmdv_pkg;
    // Byte addresses of the four register slots
    localparam logic [3:0] ADDR_X   = 4'h0;
    localparam logic [3:0] ADDR_Y   = 4'h4;
    localparam logic [3:0] ADDR_Z   = 4'h8;
    localparam logic [3:0] ADDR_CTL = 4'hC;
    // Control word fields
    localparam int CTL_OP_LSB  = 0;
    localparam int CTL_ZRST    = 2;
    localparam int CTL_YRST    = 3;
    localparam int CTL_NUM_LSB = 4;
    localparam int CTL_SEQRST  = 6;
    localparam int CTL_PRESC   = 7;
    // Operation codes in control bits 1:0
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_MUL  = 2'h1;
    localparam logic [1:0] OP_DIV  = 2'h2;
    // Status word fields
    localparam int STAT_OVF  = 0;
    localparam int STAT_BUSY = 7;
    // Reset values
    localparam logic [7:0]  CTL_RESET  = 8'h00;
    localparam logic [31:0] OPND_RESET = 32'h0000_0000;
    // Widths and pulse budget
    localparam int BYTE_W = 8;
    localparam int SETUP_PULSES = 1;
    // Prescaler terminal counts: no division, divide by 2, 4, 8
    localparam logic [2:0] PRESC_TC_NONE = 3'h0;
    localparam logic [2:0] PRESC_TC_ONE  = 3'h1;
    localparam logic [2:0] PRESC_TC_TWO  = 3'h3;
    localparam logic [2:0] PRESC_TC_MANY = 3'h7;
    // Sequencer states
    typedef enum logic [1:0] {
        CMDV_IDLE = 2'b01,
        CMDV_RUN  = 2'b10
    } cmdv_state_t;
    // Registered AHB address phase
    typedef struct packed {
        logic       valid;
        logic       wr;
        logic       mapped;
        logic [3:0] addr;
    } cmdv_aphase_t;
endpackage

// ===== hdl/cmdv_step.sv
// One add/shift-right or subtract/shift-left step of the datapath.
// Assumes operands are right aligned and masked to 8N bits.
`timescale 1ns/1ps
module cmdv_step (
    input  wire logic [1:0]  op_i,
    input  wire logic [31:0] x_i,
    input  wire logic [31:0] y_i,
    input  wire logic [31:0] z_i,
    input  wire logic [31:0] msb_i,
    input  wire logic [31:0] mask_i,
    output logic      [31:0] y_o,
    output logic      [31:0] z_o
);
    wire [32:0] mul_sum = {1'b0, y_i} + (z_i[0] ? {1'b0, x_i} : 33'h0_0000_0000);
    wire        z_top   = |(z_i & msb_i);
    wire [32:0] rem     = {y_i, z_top};
    wire        ge      = rem >= {1'b0, x_i};
    wire [32:0] rem_sub = ge ? rem - {1'b0, x_i} : rem;
    wire [31:0] z_shl   = {z_i[30:0], ge};
    wire [31:0] y_mul   = mul_sum[32:1];
    wire [31:0] z_mul   = {1'b0, z_i[31:1]} | (mul_sum[0] ? msb_i : 32'h0000_0000);
    wire [31:0] y_div   = rem_sub[31:0] & mask_i;
    wire [31:0] z_div   = z_shl & mask_i;
    // Select by operation
    assign y_o = (op_i == cmdv_pkg::OP_MUL) ? y_mul :
                 (op_i == cmdv_pkg::OP_DIV) ? y_div : y_i;
    assign z_o = (op_i == cmdv_pkg::OP_MUL) ? z_mul :
                 (op_i == cmdv_pkg::OP_DIV) ? z_div : z_i;
endmodule

// ===== hdl/cmdv_shift_gen.sv
// Shift pulse generator: prescaler and 8N+1 pulse sequencer.
// Assumes clear_i synchronous and num_i stable while busy.
`timescale 1ns/1ps
module cmdv_shift_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clear_i,
    input  wire logic       start_i,
    input  wire logic       presc_i,
    input  wire logic [1:0] num_i,
    output logic            busy_o,
    output logic            pulse_o,
    output logic            first_o,
    output logic            done_o
);
    cmdv_pkg::cmdv_state_t state_q;   // Sequencer state
    logic [2:0]            div_q;     // Prescaler count
    logic [5:0]            cnt_q;     // Pulses still due
    // Pulses per operation, 8N+1
    wire [5:0] total = 6'((int'(num_i) + 1) * cmdv_pkg::BYTE_W + cmdv_pkg::SETUP_PULSES);
    wire [2:0] div_tc = !presc_i      ? cmdv_pkg::PRESC_TC_NONE :
                        (num_i == 2'h0) ? cmdv_pkg::PRESC_TC_ONE :
                        (num_i == 2'h1) ? cmdv_pkg::PRESC_TC_TWO : cmdv_pkg::PRESC_TC_MANY;
    assign busy_o  = (state_q == cmdv_pkg::CMDV_RUN);
    assign pulse_o = busy_o && (div_q == div_tc);
    assign first_o = pulse_o && (cnt_q == total);
    assign done_o  = pulse_o && (cnt_q == 6'h01);
    // Sequencer and prescaler
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= cmdv_pkg::CMDV_IDLE;
            div_q   <= 3'h0;
            cnt_q   <= 6'h00;
        end else if (clear_i) begin
            state_q <= cmdv_pkg::CMDV_IDLE;
            div_q   <= 3'h0;
            cnt_q   <= 6'h00;
        end else begin
            unique case (state_q)
                cmdv_pkg::CMDV_IDLE: begin
                    div_q <= 3'h0;
                    if (start_i) begin
                        state_q <= cmdv_pkg::CMDV_RUN;
                        cnt_q   <= total;
                    end
                end
                cmdv_pkg::CMDV_RUN: begin
                    div_q <= pulse_o ? 3'h0 : div_q + 3'h1;
                    if (pulse_o) begin
                        cnt_q <= cnt_q - 6'h01;
                    end
                    if (done_o) begin
                        state_q <= cmdv_pkg::CMDV_IDLE;
                    end
                end
                default: begin
                    state_q <= cmdv_pkg::CMDV_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== sim/cmdv_host.sv
// Host model: an AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module cmdv_host (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic      [31:0] haddr_o,
    output logic      [1:0]  htrans_o,
    output logic             hwrite_o,
    output logic      [2:0]  hsize_o,
    output logic      [31:0] hwdata_o
);
    // Bus idle at time zero
    initial begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0000_0000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h0000_0000;
    end
    // One transfer, entered just after a rising edge
    // register chosen by address
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o   <= 1'b1;
        haddr_o  <= a;
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        hwdata_o <= ~hwdata_o;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_o   <= 1'b0;
        htrans_o <= 2'h0;
        if (wr) begin
            hwdata_o <= {24'h00_0000, d[7:0]};
        end
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench of the multiply/divide unit.
// Assumes the host model drives the bus; the bench itself drives the 20 MHz clock.
`timescale 1ns/1ps
module tb;
    // One table row: operands, control bits, results
    typedef struct packed {
        logic [2:0]  n;
        logic [7:0]  ctl;
        logic [31:0] x, y, z, ey, ez;
        logic        ovf, res;
    } cmdv_row_t;
    localparam logic [31:0] AX   = {28'h000_0000, cmdv_pkg::ADDR_X};
    localparam logic [31:0] AY   = {28'h000_0000, cmdv_pkg::ADDR_Y};
    localparam logic [31:0] AZ   = {28'h000_0000, cmdv_pkg::ADDR_Z};
    localparam logic [31:0] ACTL = {28'h000_0000, cmdv_pkg::ADDR_CTL};
    logic        mclk, rst_n, clear_n, hsel, hwrite, hreadyout, hresp, overflow_n;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          errors, checks_done;
    cmdv_row_t   rows [0:5];

    cmdv_top i_cmdv_top (.mclk_i(mclk), .rst_n_i(rst_n), .clear_n_i(clear_n),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .overflow_n_o(overflow_n));
    cmdv_host i_cmdv_host (.clk_i(mclk), .hready_i(hreadyout), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));

    // Clock of 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus cycles through the host model
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_cmdv_host.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        i_cmdv_host.xfer(1'b0, a, 32'h0000_0000, r);
        chk("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask
    // Control word with cascade count in bits 5:4
    function automatic logic [31:0] ctl(input logic [2:0] n, input logic [7:0] b);
        logic [7:0] w;
        w = b;
        w[5:4] = 2'(n - 3'h1);
        return {24'h00_0000, w};
    endfunction
    // Whole register, most significant slice first
    task automatic put(input logic [31:0] a, input logic [31:0] v, input logic [2:0] n);
        if (n != 3'h4) begin
            wr(ACTL, ctl(n, 8'h40));
        end
        for (int b = int'(n) - 1; b >= 0; b--) begin
            wr(a, {24'h00_0000, v[8*b +: 8]});
        end
    endtask
    task automatic get(input logic [31:0] a, input logic [31:0] v, input logic [2:0] n,
                       input string nm);
        logic [31:0] r;
        if (n != 3'h4) begin
            wr(ACTL, ctl(n, 8'h40));
        end
        for (int b = int'(n) - 1; b >= 0; b--) begin
            rd(a, r);
            chk(nm, r, {24'h00_0000, v[8*b +: 8]});
        end
    endtask
    // Load, run, time and read back one table row
    task automatic run_row(input cmdv_row_t r);
        int t;
        logic [31:0] s;
        t = (8 * int'(r.n) + 1) * (!r.ctl[7] ? 1 : (r.n == 3'h1) ? 2 : (r.n == 3'h2) ? 4 : 8);
        wr(ACTL, ctl(r.n, 8'h40));
        put(AX, r.x, r.n);
        put(AY, r.y, r.n);
        put(AZ, r.z, r.n);
        rd(ACTL, s);
        chk("idle after loads", {31'h0, s[7]}, 32'h0000_0000);
        wr(ACTL, ctl(r.n, r.ctl));
        wr(AX, 32'h0000_00FF);
        rd(AZ, s);
        chk("read while busy", s, 32'h0000_0000);
        repeat (t - 6) @(posedge mclk);
        rd(ACTL, s);
        chk("busy", s, {24'h00_0000, 7'h40, r.ovf});
        rd(ACTL, s);
        chk("done", s, {31'h0, r.ovf});
        chk("overflow_n", {31'h0, overflow_n}, {31'h0, !r.ovf});
        wr(ACTL, ctl(r.n, 8'h40));
        get(AX, r.x, r.n, "x kept");
        if (r.res) begin
            get(AY, r.ey, r.n, "y result");
            get(AZ, r.ez, r.n, "z result");
        end
        $display("test row n=%0d ctl=%h done", r.n, r.ctl);
    endtask
    // Summary and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        test_done();
    end
    // Main sequence
    initial begin
        errors      = 0;
        checks_done = 0;
        rst_n       = 1'b0;
        clear_n     = 1'b1;
        rows = '{
            '{3'h1, 8'h01, 32'h0F, 32'h03, 32'h11, 32'h01, 32'h02, 1'b0, 1'b1},
            '{3'h2, 8'h82, 32'h0100, 32'h0012, 32'h3456, 32'h0056, 32'h1234, 1'b0, 1'b1},
            '{3'h3, 8'h89, 32'h000100, 32'hABCDEF, 32'h123456, 32'h000012, 32'h345600,
              1'b0, 1'b1},
            '{3'h4, 8'h02, 32'h0001_0000, 32'h0000_1234, 32'h5678_9ABC, 32'h0000_9ABC,
              32'h1234_5678, 1'b0, 1'b1},
            '{3'h4, 8'h81, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
              32'h0000_0000, 1'b1, 1'b1},
            '{3'h1, 8'h86, 32'h05, 32'h07, 32'h00, 32'h00, 32'h00, 1'b1, 1'b0}};
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(ACTL, q);
        chk("status at reset", q, 32'h0000_0000);
        chk("overflow_n at reset", {31'h0, overflow_n}, 32'h0000_0001);
        $display("test reset done");
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        wr(ACTL, ctl(3'h4, 8'h40));
        put(AX, 32'h1122_3344, 3'h4);
        get(AX, 32'h1122_3344, 3'h4, "x after wrap");
        rd(AX, q);
        chk("second wrap", q, 32'h0000_0011);
        $display("test wrap done");
        wr(ACTL, ctl(3'h2, 8'h40));
        get(AX, 32'h0000_3344, 3'h2, "two slices");
        rd(AX, q);
        chk("no slice selected", q, 32'h0000_0000);
        wr(32'h0000_0010, 32'h0000_005A);
        rd(32'h0000_0010, q);
        chk("unmapped", q, 32'h0000_0000);
        $display("test select done");
        wr(ACTL, ctl(3'h4, 8'h81));
        repeat (10) @(posedge mclk);
        clear_n <= 1'b0;
        @(posedge mclk);
        clear_n <= 1'b1;
        rd(ACTL, q);
        chk("busy after clear", {31'h0, q[7]}, 32'h0000_0000);
        rd(AX, q);
        chk("first slice after clear", q, 32'h0000_0011);
        $display("test clear done");
        test_done();
    end
endmodule
